// ==== rtl/ptt_timebase.sv ====
// Periodic tick timebase: control register, pending flag, interrupt
`timescale 1ns/1ps
module ptt_timebase (
  // Clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_b_i,
  // Register port
  input  wire logic [ptt_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [ptt_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [ptt_pkg::DATA_W-1:0]  reg_rdata_o,
  // Configuration options
  input  wire logic                        prescale128_select_i,
  input  wire logic                        osc_keep_in_stop_i,
  // Low power mode status
  input  wire logic                        wait_mode_i,
  input  wire logic                        stop_mode_i,
  // Interrupt and wakeup
  output logic                             irq_o,
  output logic                             wakeup_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ptt_div_if div_bus ();                       // Link to the divider chain

  logic                       run_q;           // timebase_run
  logic                       ie_q;            // tick_irq_enable
  logic [ptt_pkg::TAP_W-1:0]  tap_q;           // tap_select
  logic                       pend_q;          // tick_pending_flag
  logic [ptt_pkg::DATA_W-1:0] rdata_q;         // Read data, one cycle late
  logic [ptt_pkg::DATA_W-1:0] rd_mux;          // Read data before the flop
  logic                       access_ok;       // CPU may reach the registers
  logic                       wr_ctrl;         // Write to timebase_control
  logic                       wr_en;           // Write to the enable register
  logic                       ack;             // Acknowledge of the tick flag
  logic                       clk_frozen;      // Source clock off in stop

  // ----------------------------------------------------------------
  // Mode gating
  // ----------------------------------------------------------------
  // The register is unreachable in wait and stop; bus cycles then do nothing
  assign access_ok  = !wait_mode_i && !stop_mode_i;
  // Without the kept oscillator the chain has no clock in stop mode
  assign clk_frozen = stop_mode_i && !osc_keep_in_stop_i;

  // Decoded write strobes
  assign wr_ctrl = reg_wr_i && access_ok && (reg_addr_i == ptt_pkg::ADDR_CTRL);
  assign wr_en   = reg_wr_i && access_ok && (reg_addr_i == ptt_pkg::ADDR_EN);

  // Acknowledge comes either from the control register or the clear register
  always_comb begin
    ack = 1'b0;
    if (reg_wr_i && access_ok) begin
      if (reg_addr_i == ptt_pkg::ADDR_CTRL) begin
        ack = reg_wdata_i[ptt_pkg::CTRL_ACK];
      end else if (reg_addr_i == ptt_pkg::ADDR_CLR) begin
        ack = reg_wdata_i[ptt_pkg::EV_TICK];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  // Run bit; clearing it also zeroes the chain, so a toggle restarts it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      run_q <= 1'b0;
    end else if (wr_ctrl) begin
      run_q <= reg_wdata_i[ptt_pkg::CTRL_RUN];
    end
  end

  // Interrupt enable, reachable in the control and the enable register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ie_q <= 1'b0;
    end else if (wr_ctrl) begin
      ie_q <= reg_wdata_i[ptt_pkg::CTRL_IE];
    end else if (wr_en) begin
      ie_q <= reg_wdata_i[ptt_pkg::EV_TICK];
    end
  end

  // Tap select; software is expected to change it only while stopped,
  // a change while running moves the next tick and can trip the a_exact_period check
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      tap_q <= '0;
    end else if (wr_ctrl) begin
      tap_q <= reg_wdata_i[ptt_pkg::CTRL_TAP_LO +: ptt_pkg::TAP_W];
    end
  end

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  // The chain runs straight on the reference clock, which is the source clock
  assign div_bus.run    = run_q;
  assign div_bus.freeze = clk_frozen;
  assign div_bus.pre128 = prescale128_select_i;
  assign div_bus.tap    = tap_q;

  ptt_divider u_divider (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .bus       (div_bus.div)
  );

  // ----------------------------------------------------------------
  // Pending flag
  // ----------------------------------------------------------------
  // A tick in the same cycle as an acknowledge wins, so no tick is lost
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pend_q <= 1'b0;
    end else if (div_bus.tick) begin
      pend_q <= 1'b1;
    end else if (ack) begin
      pend_q <= 1'b0;
    end
  end

  // Level interrupt; in stop with the oscillator kept it is also the wakeup
  assign irq_o    = pend_q && ie_q;
  assign wakeup_o = irq_o && stop_mode_i && osc_keep_in_stop_i;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Acknowledge position always reads zero; clear register reads zero
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr_i)
      ptt_pkg::ADDR_CTRL: begin
        rd_mux[ptt_pkg::CTRL_FLAG]                      = pend_q;
        rd_mux[ptt_pkg::CTRL_TAP_LO +: ptt_pkg::TAP_W]  = tap_q;
        rd_mux[ptt_pkg::CTRL_IE]                        = ie_q;
        rd_mux[ptt_pkg::CTRL_RUN]                       = run_q;
        rd_mux[ptt_pkg::CTRL_ACK]                       = 1'b0;
      end
      ptt_pkg::ADDR_STAT: begin
        rd_mux[ptt_pkg::EV_TICK] = pend_q;
      end
      ptt_pkg::ADDR_EN: begin
        rd_mux[ptt_pkg::EV_TICK] = ie_q;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe; zero otherwise
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i && access_ok) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_tick_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    div_bus.tick |=> pend_q)
    else $error("tick did not set pending flag");

  // A tick while enabled must reach the interrupt line one cycle later
  a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    div_bus.tick && ie_q && !wr_ctrl && !wr_en |=> irq_o)
    else $error("interrupt does not follow pending and enable");

  a_ack_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    reg_wr_i && access_ok && (reg_addr_i == ptt_pkg::ADDR_CTRL)
      && reg_wdata_i[ptt_pkg::CTRL_ACK] && !div_bus.tick |=> !pend_q)
    else $error("acknowledge did not clear pending flag");

  a_ack_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    reg_wr_i && (reg_addr_i == ptt_pkg::ADDR_CTRL) && pend_q
      && !reg_wdata_i[ptt_pkg::CTRL_ACK] |=> pend_q)
    else $error("writing zero to acknowledge changed the flag");

  a_ack_reads0: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    reg_rd_i && (reg_addr_i == ptt_pkg::ADDR_CTRL) |=> !reg_rdata_o[ptt_pkg::CTRL_ACK])
    else $error("acknowledge bit read as one");

  a_wait_locked: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    reg_wr_i && wait_mode_i |=> $stable(run_q) && $stable(ie_q) && $stable(tap_q))
    else $error("register written in wait mode");

  // Wait mode alone must never slow the chain; stop may follow at once
  a_wait_counts: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wait_mode_i && !stop_mode_i && run_q
      |=> div_bus.count == $past(div_bus.count) + ptt_pkg::CNT_W'(1))
    else $error("divider frozen in wait mode");

  a_stop_rdzero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    reg_rd_i && stop_mode_i |=> reg_rdata_o == '0)
    else $error("register readable in stop mode");

  a_reset_clear: assert property (@(posedge ref_clk_i)
    !rst_b_i |=> !ie_q && !run_q && !irq_o && (div_bus.count == '0))
    else $error("reset left timebase enabled");

  a_tick_wins: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    div_bus.tick && ack |=> pend_q [*1] ##0 (irq_o == ie_q))
    else $error("tick lost against acknowledge");

endmodule

// ==== rtl/ptt_pkg.sv ====
// Package of constants for the periodic tick timebase
package ptt_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry and register addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;           // Register address width
  localparam int unsigned DATA_W = 8;           // Register data width

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;  // timebase_control
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h1;  // Sticky event status, read only
  localparam logic [ADDR_W-1:0] ADDR_CLR  = 4'h2;  // Event clear, write only
  localparam logic [ADDR_W-1:0] ADDR_EN   = 4'h3;  // Event interrupt enable

  // ----------------------------------------------------------------
  // Field positions of timebase_control
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_RUN    = 1;      // timebase_run
  localparam int unsigned CTRL_IE     = 2;      // tick_irq_enable
  localparam int unsigned CTRL_ACK    = 3;      // tick_acknowledge, write only
  localparam int unsigned CTRL_TAP_LO = 4;      // tap_select, bits 6:4
  localparam int unsigned CTRL_FLAG   = 7;      // tick_pending_flag, read only
  localparam int unsigned TAP_W       = 3;      // tap_select width
  localparam int unsigned EV_TICK     = 0;      // Tick bit in status/clear/enable

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  localparam int unsigned DIV_STAGES = 15;      // Main divider stages
  localparam int unsigned PRE_STAGES = 7;       // Optional divide-by-128
  localparam int unsigned CNT_W      = DIV_STAGES + PRE_STAGES;
  localparam int unsigned SHIFT_W    = 5;       // Holds a stage index
  localparam logic [SHIFT_W-1:0] PRE_LOG2 = 5'h07;
  // Log2 of the divide ratio for each tap code 000..111
  localparam logic [SHIFT_W-1:0] TAP_LOG2 [8] = '{
    5'h0f, 5'h0d, 5'h0b, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03
  };

endpackage

// ==== rtl/ptt_div_if.sv ====
// Interface between the timebase registers and its divider chain
`timescale 1ns/1ps
interface ptt_div_if;
  logic                           run;     // Count enable, zero clears count
  logic                           freeze;  // Hold count, clock stopped in stop mode
  logic                           pre128;  // Extra divide-by-128 in front
  logic [ptt_pkg::TAP_W-1:0]      tap;     // Selected tap code
  logic                           tick;    // One-cycle rollover pulse
  logic [ptt_pkg::CNT_W-1:0]      count;   // Divider count, for checks

  // Register side drives control, sees ticks
  modport ctrl (output run, output freeze, output pre128, output tap,
                input tick, input count);
  // Divider side
  modport div (input run, input freeze, input pre128, input tap,
               output tick, output count);
endinterface

// ==== rtl/ptt_divider.sv ====
// Divider chain with tap selection and rollover pulse
`timescale 1ns/1ps
module ptt_divider (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  // Control from the register block
  ptt_div_if.div    bus
);

  // ----------------------------------------------------------------
  // Tap decode
  // ----------------------------------------------------------------
  logic [ptt_pkg::CNT_W-1:0]   cnt_q;      // Divider chain
  logic                        tick_q;     // Registered rollover pulse
  logic [ptt_pkg::SHIFT_W-1:0] tap_bit;    // Stage whose rise marks a tick
  logic [ptt_pkg::CNT_W-1:0]   low_mask;   // Stages below the tap
  logic [ptt_pkg::CNT_W-1:0]   full_mask;  // Stages up to the tap
  logic                        hit;        // Tap stage about to rise

  // Prescaler just moves every tap up by seven stages
  always_comb begin
    tap_bit   = ptt_pkg::TAP_LOG2[bus.tap] - 5'h01
              + (bus.pre128 ? ptt_pkg::PRE_LOG2 : 5'h00);
    low_mask  = (ptt_pkg::CNT_W'(1) << tap_bit) - ptt_pkg::CNT_W'(1);
    full_mask = low_mask | (ptt_pkg::CNT_W'(1) << tap_bit);
    // Rise of stage (log2 ratio - 1): first after half a period, then every period
    hit       = (cnt_q & full_mask) == low_mask;
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Cleared while stopped so a stop then start restarts the count
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || !bus.run) begin
      cnt_q <= '0;
    end else if (!bus.freeze) begin
      cnt_q <= cnt_q + ptt_pkg::CNT_W'(1);
    end
  end

  // Rollover pulse, suppressed while the clock is frozen
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= bus.run && !bus.freeze && hit;
    end
  end

  assign bus.tick  = tick_q;
  assign bus.count = cnt_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [ptt_pkg::CNT_W:0] gap_q;   // Cycles since the last tick
  logic                    seen_q;  // A tick was seen in an unbroken run

  // Helper: measure spacing between ticks
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || !bus.run || bus.freeze) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end else if (tick_q) begin
      gap_q  <= '0;
      seen_q <= 1'b1;
    end else begin
      gap_q  <= gap_q + (ptt_pkg::CNT_W + 1)'(1);
    end
  end

  a_hold_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !bus.run |=> (cnt_q == '0) && !tick_q)
    else $error("divider not held at zero while stopped");

  a_count_adv: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    bus.run && !bus.freeze |=> cnt_q == $past(cnt_q) + ptt_pkg::CNT_W'(1))
    else $error("divider did not advance while running");

  a_exact_period: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    tick_q && seen_q && !bus.freeze
      |-> gap_q == ((ptt_pkg::CNT_W + 1)'(1) << (tap_bit + 5'h01)) - 1)
    else $error("tick spacing differs from selected period");

  a_stop_frozen: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    bus.run && bus.freeze |=> $stable(cnt_q) && !tick_q)
    else $error("divider moved while frozen in stop");

endmodule

// ==== sim/test_ptt_timebase.sv ====
// Self-checking testbench for the periodic tick timebase
`timescale 1ns/1ps
module test_ptt_timebase;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic       ref_clk_i;                 // 25 MHz reference clock
  logic       rst_b_i;                   // Synchronous reset, active low
  logic [3:0] reg_addr;                  // Register address
  logic [7:0] reg_wdata;                 // Write data
  logic       reg_wr;                    // Write strobe
  logic       reg_rd;                    // Read strobe
  logic [7:0] reg_rdata;                 // Read data
  logic       pre_sel;                   // Extra divide-by-128 option
  logic       osc_keep;                  // Oscillator kept in stop
  logic       wait_md;                   // CPU wait mode
  logic       stop_md;                   // CPU stop mode
  logic       irq;                       // Interrupt request
  logic       wake;                      // Wakeup from stop
  int         cyc;                       // Free cycle count, read at falling edges
  int         num_errors;                // Mismatches seen
  int         checks;                    // Comparisons made
  int         ratio [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

  // ----------------------------------------------------------------
  // Device under test
  // ----------------------------------------------------------------
  ptt_timebase uut (
    .ref_clk_i            (ref_clk_i),
    .rst_b_i              (rst_b_i),
    .reg_addr_i           (reg_addr),
    .reg_wdata_i          (reg_wdata),
    .reg_wr_i             (reg_wr),
    .reg_rd_i             (reg_rd),
    .reg_rdata_o          (reg_rdata),
    .prescale128_select_i (pre_sel),
    .osc_keep_in_stop_i   (osc_keep),
    .wait_mode_i          (wait_md),
    .stop_mode_i          (stop_md),
    .irq_o                (irq),
    .wakeup_o             (wake)
  );

  // Clock generator, half period 20 ns
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // Cycle stamp, sampled only at falling edges to avoid races
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Verdict and end of run, the only exit point
  task automatic conclude();
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compare and count; unknowns never match
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe; takes effect at the edge that ends it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk_i);
    reg_wr    <= 1'b0;
  endtask

  // One-cycle read strobe; data stand only in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk_i);
    reg_rd   <= 1'b0;
    @(negedge ref_clk_i);
    d = reg_rdata;
  endtask

  // Bounded wait for the interrupt level, returns the cycle it was seen
  task automatic wait_irq(input int lim, output int t);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    while (irq !== 1'b1 && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
    t = cyc;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Values straight after reset
  task automatic reset_values();
    logic [7:0] d;
    rd(ptt_pkg::ADDR_CTRL, d);
    chk(d, 8'h00, "control after reset");
    rd(ptt_pkg::ADDR_EN, d);
    chk(d, 8'h00, "enable after reset");
    chk({6'h00, irq, wake}, 8'h00, "irq and wakeup after reset");
  endtask

  // Half period first, exact period next, restart clears the count
  task automatic rate_case(input logic pre_v, input logic [2:0] tap, input int r);
    int t0;
    int t1;
    int t2;
    @(posedge ref_clk_i);
    pre_sel <= pre_v;
    wr(ptt_pkg::ADDR_CTRL, {1'b0, tap, 4'h0});
    wr(ptt_pkg::ADDR_CTRL, {1'b0, tap, 4'h6});
    @(negedge ref_clk_i);
    t0 = cyc;
    wait_irq(r + 16, t1);
    chk({7'h00, irq}, 8'h01, "first tick missing");
    chk({7'h00, (t1 - t0 >= r / 2 - 1) && (t1 - t0 <= r / 2 + 1)}, 8'h01,
        "first tick not at half period");
    wr(ptt_pkg::ADDR_CTRL, {1'b0, tap, 4'he});
    @(negedge ref_clk_i);
    chk({7'h00, irq}, 8'h00, "acknowledge did not clear");
    wait_irq(2 * r, t2);
    chk({7'h00, (t2 - t1) == r}, 8'h01, "period wrong");
    wr(ptt_pkg::ADDR_CTRL, 8'h08);
  endtask

  // Acknowledge landing on the same edge as a new tick
  task automatic ack_collision();
    int p;
    wr(ptt_pkg::ADDR_CTRL, 8'h70);
    wr(ptt_pkg::ADDR_CTRL, 8'h76);
    wait_irq(24, p);
    wr(ptt_pkg::ADDR_CTRL, 8'h7e);
    while (cyc < p + 8 - 2) begin
      @(negedge ref_clk_i);
    end
    wr(ptt_pkg::ADDR_CTRL, 8'h7e);
    @(negedge ref_clk_i);
    chk({7'h00, irq}, 8'h01, "tick lost to acknowledge");
    wr(ptt_pkg::ADDR_CTRL, 8'h78);
  endtask

  // Wait and stop modes, then status, clear and enable registers
  task automatic low_power();
    logic [7:0] d;
    int         t;
    wr(ptt_pkg::ADDR_CTRL, 8'h76);
    @(posedge ref_clk_i);
    wait_md <= 1'b1;
    wr(ptt_pkg::ADDR_CTRL, 8'h00);
    rd(ptt_pkg::ADDR_CTRL, d);
    chk(d, 8'h00, "read in wait mode");
    wait_irq(24, t);
    chk({7'h00, irq}, 8'h01, "no tick in wait mode");
    @(posedge ref_clk_i);
    wait_md <= 1'b0;
    // Acknowledge right after a tick so no tick is due before stop
    wr(ptt_pkg::ADDR_CTRL, 8'h7e);
    @(posedge ref_clk_i);
    stop_md <= 1'b1;
    rd(ptt_pkg::ADDR_CTRL, d);
    chk(d, 8'h00, "read in stop mode");
    repeat (40) @(negedge ref_clk_i);
    chk({6'h00, irq, wake}, 8'h00, "tick in stop without oscillator");
    @(posedge ref_clk_i);
    osc_keep <= 1'b1;
    wait_irq(12, t);
    chk({6'h00, irq, wake}, 8'h03, "no wakeup in stop");
    @(posedge ref_clk_i);
    stop_md  <= 1'b0;
    osc_keep <= 1'b0;
    @(negedge ref_clk_i);
    chk({7'h00, wake}, 8'h00, "wakeup outside stop");
    rd(ptt_pkg::ADDR_CTRL, d);
    chk(d, 8'hf6, "control with flag set");
    wr(ptt_pkg::ADDR_EN, 8'h00);
    @(negedge ref_clk_i);
    chk({7'h00, irq}, 8'h00, "irq while disabled");
    wr(ptt_pkg::ADDR_CTRL, 8'h70);
    rd(ptt_pkg::ADDR_STAT, d);
    chk(d, 8'h01, "acknowledge written as zero cleared");
    wr(ptt_pkg::ADDR_STAT, 8'h00);
    rd(ptt_pkg::ADDR_STAT, d);
    chk(d, 8'h01, "status is writable");
    wr(ptt_pkg::ADDR_CLR, 8'h01);
    rd(ptt_pkg::ADDR_STAT, d);
    chk(d, 8'h00, "clear register failed");
    rd(ptt_pkg::ADDR_CLR, d);
    chk(d, 8'h00, "clear register read");
    rd(4'hf, d);
    chk(d, 8'h00, "unmapped read");
    wr(ptt_pkg::ADDR_EN, 8'h01);
    rd(ptt_pkg::ADDR_CTRL, d);
    chk(d, 8'h74, "enable register not shared");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_b_i   = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    pre_sel   = 1'b0;
    osc_keep  = 1'b0;
    wait_md   = 1'b0;
    stop_md   = 1'b0;
    cyc       = 0;
    num_errors = 0;
    checks    = 0;
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    reset_values();
    for (int i = 7; i >= 0; i--) begin
      rate_case(1'b0, 3'(i), ratio[i]);
    end
    rate_case(1'b1, 3'h7, 1024);
    rate_case(1'b1, 3'h6, 2048);
    @(posedge ref_clk_i);
    pre_sel <= 1'b0;
    ack_collision();
    low_power();
    conclude();
  end

  // Whole run should need about 70k cycles
  initial begin
    repeat (95000) @(posedge ref_clk_i);
    num_errors++;
    conclude();
  end
endmodule
